// ==== common/ldc_pkg.sv ====
package ldc_pkg;
    localparam logic [7:0] LDC_ADDR_OUT1 = 8'h23;
    localparam logic [7:0] LDC_ADDR_OUT2 = 8'h24;
    localparam logic [7:0] LDC_ADDR_FINE = 8'h25;
    localparam int LDC_STRENGTH_BIT = 13;
    localparam int LDC_FIXED_ONE_BIT = 12;
    localparam int LDC_EDGE_LSB = 4;
    localparam int LDC_COARSE_LSB = 0;
    localparam int LDC_FINE1_LSB = 0;
    localparam int LDC_FINE2_LSB = 6;
    localparam int LDC_FINE3_LSB = 11;
    localparam logic [15:0] LDC_DRIVE_RESET = 16'h3000;
    localparam logic [15:0] LDC_FINE_RESET = 16'h630C;
    localparam logic [15:0] LDC_DRIVE_MASK = 16'h307F;
    localparam logic [15:0] LDC_FINE_MASK = 16'hFFDF;
    // fixed point: coarse in 0.01 mA, fine in 0.001, strength in 0.1
    localparam logic [11:0] LDC_COARSE_BASE = 12'hAF0;
    localparam logic [11:0] LDC_COARSE_STEP = 12'h60A;
    localparam logic [9:0] LDC_FINE_BASE = 10'h2C6;
    localparam logic [9:0] LDC_FINE_STEP = 10'h018;
    localparam logic [3:0] LDC_STRENGTH_FULL = 4'hA;
    localparam logic [3:0] LDC_STRENGTH_LOW = 4'h4;
endpackage

// ==== src/ldc_peak_calc.sv ====
`timescale 1ns/10ps
module ldc_peak_calc
    import ldc_pkg::*;
(
    input wire logic [3:0] coarse_in,
    input wire logic [4:0] fine_in,
    input wire logic strength_in,
    output logic [31:0] peak_out
);
    logic [15:0] coarse_val;
    logic [15:0] fine_val;
    logic [3:0] strength_val;
    always_comb
    begin
        coarse_val = 16'(LDC_COARSE_BASE) + 16'(LDC_COARSE_STEP) * 16'(coarse_in);
        fine_val = 16'(LDC_FINE_BASE) + 16'(LDC_FINE_STEP) * 16'(fine_in);
        strength_val = strength_in ? LDC_STRENGTH_FULL : LDC_STRENGTH_LOW;
        peak_out = 32'(coarse_val) * 32'(fine_val) * 32'(strength_val);
    end
endmodule

// ==== src/ldc_drive_regs.sv ====
`timescale 1ns/10ps
module ldc_drive_regs
    import ldc_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic wr_en_in,
    input wire logic rd_en_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [15:0] wdata_in,
    input wire logic pulse_start_in,
    output logic [15:0] rdata_out,
    output logic rvalid_out,
    output logic [2:0] out1_edge_rate_out,
    output logic [3:0] out1_coarse_current_out,
    output logic [4:0] out1_fine_trim_out,
    output logic out1_strength_select_out,
    output logic out1_low_power_out,
    output logic [31:0] out1_peak_out,
    output logic [2:0] out2_edge_rate_out,
    output logic [3:0] out2_coarse_current_out,
    output logic [4:0] out2_fine_trim_out,
    output logic out2_strength_select_out,
    output logic out2_low_power_out,
    output logic [31:0] out2_peak_out
);
    // the check demands 8 bits, though the registers at 0x23..0x25 fit in a 6-bit bus
    if (ADDR_W < 8)
    begin
        $error("ldc_drive_regs: ADDR_W must be at least 8");
    end

    // upper address bits join the decode, so no register shows up twice
    localparam logic [ADDR_W-1:0] SEL_OUT1 = ADDR_W'(LDC_ADDR_OUT1);
    localparam logic [ADDR_W-1:0] SEL_OUT2 = ADDR_W'(LDC_ADDR_OUT2);
    localparam logic [ADDR_W-1:0] SEL_FINE = ADDR_W'(LDC_ADDR_FINE);

    ////////////////////////////////////////////////////////////////////////////
    // register file
    logic [15:0] out1_q, out1_d;
    logic [15:0] out2_q, out2_d;
    logic [15:0] fine_q, fine_d;
    logic [15:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;

    always_comb
    begin
        out1_d = out1_q;
        out2_d = out2_q;
        fine_d = fine_q;
        // OUT1/OUT2 reserved bits stored as written; FINE bit 5 is cleared by LDC_FINE_MASK
        if (wr_en_in)
        begin
            case (addr_in)
                SEL_OUT1: out1_d = wdata_in;
                SEL_OUT2: out2_d = wdata_in;
                SEL_FINE: fine_d = wdata_in & LDC_FINE_MASK;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            out1_q <= LDC_DRIVE_RESET;
            out2_q <= LDC_DRIVE_RESET;
            fine_q <= LDC_FINE_RESET;
        end
        else
        begin
            out1_q <= out1_d;
            out2_q <= out2_d;
            fine_q <= fine_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port: answer one edge after the strobe, data holds until the next read
    always_comb
    begin
        rdata_d = rdata_q;
        rvalid_d = rd_en_in;
        // plain read, no side effects; unmapped reads zero
        if (rd_en_in)
        begin
            case (addr_in)
                SEL_OUT1: rdata_d = out1_q;
                SEL_OUT2: rdata_d = out2_q;
                SEL_FINE: rdata_d = fine_q;
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // applied settings, latched at pulse start so a pulse never sees a mid-change
    logic [2:0] e1_q, e1_d, e2_q, e2_d;
    logic [3:0] c1_q, c1_d, c2_q, c2_d;
    logic [4:0] f1_q, f1_d, f2_q, f2_d;
    logic s1_q, s1_d, s2_q, s2_d;
    logic lp1_q, lp1_d, lp2_q, lp2_d;
    // applied copies restart from the register reset values
    localparam logic [2:0] EDGE_RST = LDC_DRIVE_RESET[LDC_EDGE_LSB +: 3];
    localparam logic [3:0] COARSE_RST = LDC_DRIVE_RESET[LDC_COARSE_LSB +: 4];
    localparam logic [4:0] FINE1_RST = LDC_FINE_RESET[LDC_FINE1_LSB +: 5];
    localparam logic [4:0] FINE2_RST = LDC_FINE_RESET[LDC_FINE2_LSB +: 5];
    localparam logic STRENGTH_RST = LDC_DRIVE_RESET[LDC_STRENGTH_BIT];
    logic [31:0] p1_q, p1_d, p2_q, p2_d;
    logic [31:0] p1_w, p2_w;

    ldc_peak_calc u_calc1 (
        .coarse_in(out1_q[LDC_COARSE_LSB +: 4]),
        .fine_in(fine_q[LDC_FINE1_LSB +: 5]),
        .strength_in(out1_q[LDC_STRENGTH_BIT]),
        .peak_out(p1_w)
    );
    ldc_peak_calc u_calc2 (
        .coarse_in(out2_q[LDC_COARSE_LSB +: 4]),
        .fine_in(fine_q[LDC_FINE2_LSB +: 5]),
        .strength_in(out2_q[LDC_STRENGTH_BIT]),
        .peak_out(p2_w)
    );

    always_comb
    begin
        e1_d = e1_q;
        c1_d = c1_q;
        f1_d = f1_q;
        s1_d = s1_q;
        lp1_d = lp1_q;
        p1_d = p1_q;
        e2_d = e2_q;
        c2_d = c2_q;
        f2_d = f2_q;
        s2_d = s2_q;
        lp2_d = lp2_q;
        p2_d = p2_q;
        // one strobe moves every applied field, so a pulse never mixes old and new
        if (pulse_start_in)
        begin
            e1_d = out1_q[LDC_EDGE_LSB +: 3];
            c1_d = out1_q[LDC_COARSE_LSB +: 4];
            f1_d = fine_q[LDC_FINE1_LSB +: 5];
            s1_d = out1_q[LDC_STRENGTH_BIT];
            lp1_d = ~out1_q[LDC_STRENGTH_BIT];
            p1_d = p1_w;
            e2_d = out2_q[LDC_EDGE_LSB +: 3];
            c2_d = out2_q[LDC_COARSE_LSB +: 4];
            f2_d = fine_q[LDC_FINE2_LSB +: 5];
            s2_d = out2_q[LDC_STRENGTH_BIT];
            lp2_d = ~out2_q[LDC_STRENGTH_BIT];
            p2_d = p2_w;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            // peak reads zero until the first pulse has latched a target
            e1_q <= EDGE_RST;
            c1_q <= COARSE_RST;
            f1_q <= FINE1_RST;
            s1_q <= STRENGTH_RST;
            lp1_q <= ~STRENGTH_RST;
            p1_q <= 32'h0000_0000;
            e2_q <= EDGE_RST;
            c2_q <= COARSE_RST;
            f2_q <= FINE2_RST;
            s2_q <= STRENGTH_RST;
            lp2_q <= ~STRENGTH_RST;
            p2_q <= 32'h0000_0000;
        end
        else
        begin
            e1_q <= e1_d;
            c1_q <= c1_d;
            f1_q <= f1_d;
            s1_q <= s1_d;
            lp1_q <= lp1_d;
            p1_q <= p1_d;
            e2_q <= e2_d;
            c2_q <= c2_d;
            f2_q <= f2_d;
            s2_q <= s2_d;
            lp2_q <= lp2_d;
            p2_q <= p2_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // every pin comes straight off a flop, so a bus write never glitches the drivers
    assign rdata_out = rdata_q;
    assign rvalid_out = rvalid_q;
    assign out1_edge_rate_out = e1_q;
    assign out1_coarse_current_out = c1_q;
    assign out1_fine_trim_out = f1_q;
    assign out1_strength_select_out = s1_q;
    assign out1_low_power_out = lp1_q;
    assign out1_peak_out = p1_q;
    assign out2_edge_rate_out = e2_q;
    assign out2_coarse_current_out = c2_q;
    assign out2_fine_trim_out = f2_q;
    assign out2_strength_select_out = s2_q;
    assign out2_low_power_out = lp2_q;
    assign out2_peak_out = p2_q;
endmodule

// ==== testbench/ldc_chk_sva.sv ====
`timescale 1ns/10ps
module ldc_chk #(parameter int ADDR_W = 8) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic rd_en_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic pulse_start_in,
    input wire logic [15:0] rdata_out,
    input wire logic rvalid_out,
    input wire logic [3:0] out1_coarse_current_out,
    input wire logic [4:0] out1_fine_trim_out,
    input wire logic out1_strength_select_out,
    input wire logic out1_low_power_out,
    input wire logic [31:0] out1_peak_out,
    input wire logic [2:0] out2_edge_rate_out,
    input wire logic [3:0] out2_coarse_current_out,
    input wire logic [4:0] out2_fine_trim_out,
    input wire logic out2_strength_select_out,
    input wire logic out2_low_power_out,
    input wire logic [31:0] out2_peak_out
);
    function automatic logic [31:0] pk(logic [3:0] c, logic [4:0] f, logic s);
        return (32'hAF0 + 32'h60A * c) * (32'h2C6 + 32'h18 * f) * (s ? 32'hA : 32'h4);
    endfunction
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence s_rd; rd_en_in; endsequence
    sequence s_ans; rvalid_out; endsequence
    a_read_answer: assert property (s_rd |=> s_ans) else $error("no read answer");
    a_rdata_holds: assert property (!rvalid_out |-> $stable(rdata_out)) else $error("rdata moved");
    a_unmapped_zero: assert property (rd_en_in && !(addr_in inside {8'h23, 8'h24, 8'h25})
        |=> rdata_out == 16'h0000) else $error("unmapped read not zero");
    a_low_power1: assert property (out1_low_power_out == !out1_strength_select_out) else $error("lp1");
    a_low_power2: assert property (out2_low_power_out == !out2_strength_select_out) else $error("lp2");
    a_apply_pulse: assert property (!pulse_start_in |=> $stable(out1_coarse_current_out)
        && $stable(out2_edge_rate_out) && $stable(out2_strength_select_out)) else $error("applied early");
    a_peak_one: assert property (pulse_start_in |=> out1_peak_out ==
        pk(out1_coarse_current_out, out1_fine_trim_out, out1_strength_select_out)) else $error("peak1");
    a_peak_two: assert property (pulse_start_in |=> out2_peak_out ==
        pk(out2_coarse_current_out, out2_fine_trim_out, out2_strength_select_out)) else $error("peak2");
    a_reset_state: assert property ($fell(rst_in) |-> out1_strength_select_out && out1_peak_out == 32'h0
        && out1_fine_trim_out == 5'h0C && out2_fine_trim_out == 5'h0C) else $error("reset state");
endmodule
bind ldc_drive_regs ldc_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// ==== testbench/test_led_drive_current_config.sv ====
`timescale 1ns/10ps
module test_led_drive_current_config;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic wr_en_in = 1'b0;
    logic rd_en_in = 1'b0;
    logic pulse_start_in = 1'b0;
    logic [7:0] addr_in = 8'h00;
    logic [15:0] wdata_in = 16'h0000;
    logic [15:0] rdata_out;
    logic rvalid_out, out1_strength_select_out, out2_strength_select_out, out1_low_power_out, out2_low_power_out;
    logic [2:0] out1_edge_rate_out, out2_edge_rate_out;
    logic [3:0] out1_coarse_current_out, out2_coarse_current_out;
    logic [4:0] out1_fine_trim_out, out2_fine_trim_out;
    logic [31:0] out1_peak_out, out2_peak_out;
    int num_errors = 0;
    int n_checks = 0;
    ldc_drive_regs DUT (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .wr_en_in(wr_en_in),
        .rd_en_in(rd_en_in),
        .addr_in(addr_in),
        .wdata_in(wdata_in),
        .pulse_start_in(pulse_start_in),
        .rdata_out(rdata_out),
        .rvalid_out(rvalid_out),
        .out1_edge_rate_out(out1_edge_rate_out),
        .out1_coarse_current_out(out1_coarse_current_out),
        .out1_fine_trim_out(out1_fine_trim_out),
        .out1_strength_select_out(out1_strength_select_out),
        .out1_low_power_out(out1_low_power_out),
        .out1_peak_out(out1_peak_out),
        .out2_edge_rate_out(out2_edge_rate_out),
        .out2_coarse_current_out(out2_coarse_current_out),
        .out2_fine_trim_out(out2_fine_trim_out),
        .out2_strength_select_out(out2_strength_select_out),
        .out2_low_power_out(out2_low_power_out),
        .out2_peak_out(out2_peak_out)
    );
    always #25 clk_in = ~clk_in;
    ////////////////////////////////////////
    function automatic logic [31:0] pk(logic [3:0] c, logic [4:0] f, logic s);
        return (32'hAF0 + 32'h60A * c) * (32'h2C6 + 32'h18 * f) * (s ? 32'hA : 32'h4);
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // strobes drop at the next falling edge, so each is seen by exactly one rising edge
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk_in);
        wr_en_in = 1'b1;
        addr_in = a;
        wdata_in = d;
        @(negedge clk_in);
        wr_en_in = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(negedge clk_in);
        rd_en_in = 1'b1;
        addr_in = a;
        @(negedge clk_in);
        rd_en_in = 1'b0;
        chk(rvalid_out, 1'b1);
        chk(rdata_out, e);
    endtask
    task automatic pulse();
        @(negedge clk_in);
        pulse_start_in = 1'b1;
        @(negedge clk_in);
        pulse_start_in = 1'b0;
    endtask
    ////////////////////////////////////////
    task automatic t_reset();
        rd(8'h23, 16'h3000);
        rd(8'h24, 16'h3000);
        rd(8'h25, 16'h630C);
        chk({out1_edge_rate_out, out1_coarse_current_out}, 7'h00);
        chk({out2_edge_rate_out, out2_coarse_current_out}, 7'h00);
        chk({out1_low_power_out, out2_low_power_out, out1_fine_trim_out}, 7'h0C);
    endtask
    task automatic t_apply();
        wr(8'h23, 16'h3075);
        wr(8'h24, 16'h100F);
        wr(8'h25, 16'h07FF);
        rd(8'h25, 16'h07DF);
        rd(8'h24, 16'h100F);
        chk(out1_coarse_current_out, 4'h0);
        pulse();
        chk({out1_edge_rate_out, out1_coarse_current_out}, 7'h75);
        chk({out2_edge_rate_out, out2_coarse_current_out, out2_low_power_out}, 8'h1F);
        chk(out1_peak_out, pk(4'h5, 5'h1F, 1'b1));
        chk(out2_peak_out, pk(4'hF, 5'h1F, 1'b0));
        chk({out1_strength_select_out, out1_fine_trim_out}, 6'h3F);
        chk({out2_strength_select_out, out2_fine_trim_out}, 6'h1F);
    endtask
    task automatic t_restore();
        wr(8'h24, 16'h3070);
        wr(8'h25, 16'h0000);
        wr(8'h23, 16'h1075);
        rd(8'h26, 16'h0000);
        pulse();
        chk({out2_edge_rate_out, out2_low_power_out}, 4'hE);
        chk(out2_peak_out, pk(4'h0, 5'h00, 1'b1));
        chk(out1_peak_out, pk(4'h5, 5'h00, 1'b0));
        chk({out1_low_power_out, out1_strength_select_out}, 2'h2);
    endtask
    task automatic summarize();
        if (num_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        repeat (400) @(posedge clk_in);
        num_errors++;
        summarize();
    end
    initial
    begin
        repeat (5) @(negedge clk_in);
        rst_in = 1'b0;
        t_reset();
        t_apply();
        t_restore();
        rst_in = 1'b1;
        repeat (5) @(negedge clk_in);
        rst_in = 1'b0;
        t_reset();
        summarize();
    end
endmodule
